// file: bch_cfg_regs.sv
// Bridge configuration header registers with bus, window and line decode
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "bch_params.svh"

// Operation
// - Revision byte fixed, read-only, writes ignored
// - Programming interface byte reads zero
// - Sub-class byte reads 04h
// - Base-class byte reads 06h
// - Primary timer loads master latency counter
// - Header-type byte reads one
// - Writable primary bus number, reset zero
// - Writable secondary bus number, reset zero
// - Writable subordinate bus number, reset zero
// - Secondary timer times unclaimed secondary accesses
// - I/O base low nibble reads one
// - I/O base nibble gives address 15:12
// - Upper base bits from separate register
// - I/O limit nibble, low bits all ones
module bch_cfg_regs #(
  parameter logic [7:0] REV_LEVEL = 8'h5a
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  input wire logic pri_frame_start,
  input wire logic pri_frame_active,
  output logic pri_lat_expired,
  input wire logic sec_frame_start,
  input wire logic sec_unclaimed,
  output logic sec_lat_expired,
  input wire logic [31:0] io_addr,
  input wire logic io_addr_valid,
  output logic io_fwd,
  input wire logic [31:0] mem_addr,
  output logic line_end,
  output logic line_size_ok,
  output logic [7:0] line_size,
  input wire logic [7:0] cfg_bus,
  output logic cfg_local,
  output logic cfg_behind
);

  // REV_LEVEL default is an arbitrary value, not a real part code

  // Registered state and its next value
  bch_pkg::bch_regs_s s_q;
  bch_pkg::bch_regs_s s_d;

  // Assembled I/O window bounds
  logic [31:0] io_bottom;
  logic [31:0] io_top;
  // Dword index within a line and the line mask
  logic [7:0] dw_idx;
  logic [7:0] ls_mask;
  // Line size passes the power-of-two test
  logic ls_legal;

  // Merge one byte when its enable is set
  function automatic logic [7:0] wr_byte(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic en
  );
    logic [7:0] res;
    res = en ? new_v : old_v;
    return res;
  endfunction

  // Merge a 16-bit field byte by byte
  function automatic logic [15:0] wr_half(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] en
  );
    logic [15:0] res;
    res[15:8] = en[1] ? new_v[15:8] : old_v[15:8];
    res[7:0] = en[0] ? new_v[7:0] : old_v[7:0];
    return res;
  endfunction

  // Window bounds from the nibbles and upper halves
  always_comb begin
    // Bottom: low twelve address bits are zero
    io_bottom = {s_q.io_base_up, s_q.io_base_hi, `BCH_IO_LOW_BASE};
    // Top: low twelve address bits are ones
    io_top = {s_q.io_limit_up, s_q.io_limit_hi, `BCH_IO_LOW_LIMIT};
  end

  // Line geometry for memory write and invalidate and prefetch
  always_comb begin
    // Dword index; eight bits cover the largest legal line
    dw_idx = mem_addr[9:2];
    // Mask of dwords within one line
    ls_mask = s_q.line_size - `BCH_LAT_STEP;
    // Software is trusted for power of two; still checked here
    ls_legal = ((s_q.line_size & ls_mask) == `BCH_RST_BYTE)
               && (s_q.line_size <= `BCH_LS_MAX);
  end

  // Next-state logic: bus slave plus decoders
  always_comb begin
    s_d = s_q;
    // Read data stand for one cycle only
    s_d.rdata = 32'h0000_0000;

    // Register reads
    if (cfg_rd) begin
      case (cfg_addr)
        // Identification dword, all fixed
        `BCH_OFF_CLASS: begin
          s_d.rdata[31:24] = `BCH_BASE_CLASS;
          s_d.rdata[23:16] = `BCH_SUB_CLASS;
          s_d.rdata[15:8] = `BCH_PROG_IF;
          s_d.rdata[7:0] = REV_LEVEL;
        end
        // Line size, primary timer, layout kind
        `BCH_OFF_MISC: begin
          s_d.rdata[23:16] = `BCH_HDR_KIND;
          s_d.rdata[15:8] = s_q.prim_lat;
          s_d.rdata[7:0] = s_q.line_size;
        end
        // Bus numbering and secondary timer
        `BCH_OFF_BUS: begin
          s_d.rdata = {s_q.slat, s_q.subbus, s_q.sbus, s_q.pbus};
        end
        // I/O base and limit bytes; upper half lives elsewhere
        `BCH_OFF_IO: begin
          s_d.rdata[15:12] = s_q.io_limit_hi;
          s_d.rdata[11:8] = `BCH_IO_32BIT;
          s_d.rdata[7:4] = s_q.io_base_hi;
          s_d.rdata[3:0] = `BCH_IO_32BIT;
        end
        // Upper sixteen bits of base and limit
        `BCH_OFF_IO_UP: begin
          s_d.rdata = {s_q.io_limit_up, s_q.io_base_up};
        end
        // Unmapped addresses read as zero
        default: begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Register writes; fixed fields have no storage to change
    if (cfg_wr) begin
      case (cfg_addr)
        // Only the two low bytes are writable here
        `BCH_OFF_MISC: begin
          s_d.line_size = wr_byte(s_q.line_size,
                                  cfg_wdata[7:0], cfg_be[0]);
          s_d.prim_lat = wr_byte(s_q.prim_lat,
                                 cfg_wdata[15:8], cfg_be[1]);
        end
        // All four bytes writable
        `BCH_OFF_BUS: begin
          s_d.pbus = wr_byte(s_q.pbus, cfg_wdata[7:0], cfg_be[0]);
          s_d.sbus = wr_byte(s_q.sbus, cfg_wdata[15:8], cfg_be[1]);
          s_d.subbus = wr_byte(s_q.subbus,
                               cfg_wdata[23:16], cfg_be[2]);
          s_d.slat = wr_byte(s_q.slat,
                             cfg_wdata[31:24], cfg_be[3]);
        end
        // Upper nibbles only; low nibbles are fixed
        `BCH_OFF_IO: begin
          if (cfg_be[0]) begin
            s_d.io_base_hi = cfg_wdata[7:4];
          end
          if (cfg_be[1]) begin
            s_d.io_limit_hi = cfg_wdata[15:12];
          end
        end
        // Upper halves of the window
        `BCH_OFF_IO_UP: begin
          s_d.io_base_up = wr_half(s_q.io_base_up,
                                   cfg_wdata[15:0], cfg_be[1:0]);
          s_d.io_limit_up = wr_half(s_q.io_limit_up,
                                    cfg_wdata[31:16], cfg_be[3:2]);
        end
        // Identification dword and unmapped: dropped silently
        default: begin
          s_d.pbus = s_q.pbus;
        end
      endcase
    end

    // I/O forward decision; an empty window never hits
    s_d.io_fwd = io_addr_valid
                 && (io_addr >= io_bottom)
                 && (io_addr <= io_top);

    // Line end: zero or illegal size stops after every dword
    s_d.line_ok = ls_legal && (s_q.line_size != `BCH_RST_BYTE);
    if (s_d.line_ok) begin
      s_d.line_end = ((dw_idx & ls_mask) == ls_mask);
    end else begin
      s_d.line_end = 1'b1;
    end

    // Configuration routing from the bus numbers
    s_d.cfg_local = (cfg_bus == s_q.sbus);
    s_d.cfg_behind = (cfg_bus > s_q.sbus)
                     && (cfg_bus <= s_q.subbus);
  end

  // State register; every writable field resets to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Primary master latency timer
  bch_lat_timer u_pri_tmr (
    .clk(clk),
    .rst(rst),
    .load_val(s_q.prim_lat),
    .start(pri_frame_start),
    .active(pri_frame_active),
    .expired(pri_lat_expired)
  );

  // Secondary timer watches accesses nobody has claimed
  bch_lat_timer u_sec_tmr (
    .clk(clk),
    .rst(rst),
    .load_val(s_q.slat),
    .start(sec_frame_start),
    .active(sec_unclaimed),
    .expired(sec_lat_expired)
  );

  // Outputs straight from the state register
  assign cfg_rdata = s_q.rdata;
  assign io_fwd = s_q.io_fwd;
  assign line_end = s_q.line_end;
  assign line_size_ok = s_q.line_ok;
  assign line_size = s_q.line_size;
  assign cfg_local = s_q.cfg_local;
  assign cfg_behind = s_q.cfg_behind;

endmodule

// file: bch_cfg_regs_asserts.sv
// Assertion checker for the bridge header register block
`timescale 1ns/10ps
module bch_cfg_chk #(
  parameter logic [7:0] REV_LEVEL = 8'h5a
) (
  input logic clk,
  input logic rst,
  input logic [7:0] cfg_addr,
  input logic [31:0] cfg_wdata,
  input logic [3:0] cfg_be,
  input logic cfg_wr,
  input logic cfg_rd,
  input logic [31:0] cfg_rdata,
  input logic pri_frame_active,
  input logic pri_lat_expired,
  input logic sec_unclaimed,
  input logic sec_lat_expired,
  input logic io_addr_valid,
  input logic io_fwd,
  input logic line_end,
  input logic line_size_ok,
  input logic [7:0] line_size
);
  // Single clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read data only in the slot after a read strobe
  property p_rd_idle; !$past(cfg_rd) |-> cfg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata outside slot");
  // Identity dword is fixed
  property p_id; cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata == {24'h060400, REV_LEVEL}; endproperty
  a_id: assert property (p_id) else $error("identity dword");
  property p_hdr; cfg_rd && cfg_addr == 8'h0c |=> cfg_rdata[31:16] == 16'h0001; endproperty
  a_hdr: assert property (p_hdr) else $error("header kind");
  property p_io; cfg_rd && cfg_addr == 8'h1c |=> cfg_rdata[3:0] == 4'h1; endproperty
  a_io: assert property (p_io) else $error("io width flag");
  // Line size follows an enabled write and nothing else
  property p_lsz; cfg_wr && cfg_addr == 8'h0c && cfg_be[0] |=> line_size == $past(cfg_wdata[7:0]);
  endproperty
  a_lsz: assert property (p_lsz) else $error("line size write");
  property p_lsz_hold; !(cfg_wr && cfg_addr == 8'h0c && cfg_be[0]) |=> $stable(line_size); endproperty
  a_lsz_hold: assert property (p_lsz_hold) else $error("line size moved");
  // Expiry flags hold while the frame runs, drop one cycle after it ends
  property p_pri; pri_lat_expired |=> pri_lat_expired == $past(pri_frame_active); endproperty
  a_pri: assert property (p_pri) else $error("primary expiry hold");
  property p_sec; sec_lat_expired |=> sec_lat_expired == $past(sec_unclaimed); endproperty
  a_sec: assert property (p_sec) else $error("secondary expiry hold");
  property p_fwd; io_fwd |-> $past(io_addr_valid); endproperty
  a_fwd: assert property (p_fwd) else $error("io forward without address");
  // Skipped right after reset, where line_end still shows its reset value
  property p_lend; !line_size_ok && !$past(rst) |-> line_end; endproperty
  a_lend: assert property (p_lend) else $error("line end with bad size");
  c_id: cover property (cfg_rd && cfg_addr == 8'h08);
  c_pri: cover property ($rose(pri_lat_expired));
  c_fwd: cover property (io_fwd);
endmodule
bind bch_cfg_regs bch_cfg_chk #(.REV_LEVEL(REV_LEVEL)) u_chk (.clk, .rst, .cfg_addr,
  .cfg_wdata, .cfg_be, .cfg_wr, .cfg_rd, .cfg_rdata, .pri_frame_active, .pri_lat_expired,
  .sec_unclaimed, .sec_lat_expired, .io_addr_valid, .io_fwd, .line_end, .line_size_ok,
  .line_size);

// file: bch_host.sv
// Configuration host model driving register cycles
`timescale 1ns/10ps
module bch_host (
  input logic clk,
  input logic [31:0] cfg_rdata,
  output logic [7:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  output logic [3:0] cfg_be,
  output logic cfg_wr,
  output logic cfg_rd
);
  // Idle bus at time zero
  initial begin
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
    cfg_be = 4'h0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  end
  // Address and data lines inverted after release so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_be <= b;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask
  // Data taken in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    // Taken mid-cycle where it has settled; it is gone at the next edge
    @(negedge clk);
    d = cfg_rdata;
  endtask
endmodule

// file: bch_lat_timer.sv
// Master latency timer: loads a count at frame start and flags expiry
`timescale 1ns/10ps
`include "bch_params.svh"

module bch_lat_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] load_val,
  input wire logic start,
  input wire logic active,
  output logic expired
);

  // Current and next state
  bch_pkg::bch_tmr_s s_q;
  bch_pkg::bch_tmr_s s_d;

  // Next state: count down while the frame lasts
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      // Waiting for the master to open a frame
      bch_pkg::BCH_TMR_IDLE: begin
        if (start) begin
          s_d.cnt = load_val;
          s_d.st = bch_pkg::BCH_TMR_RUN;
        end
      end
      // Counting clocks; zero load expires at once
      bch_pkg::BCH_TMR_RUN: begin
        if (!active) begin
          s_d.st = bch_pkg::BCH_TMR_IDLE;
        end else if (s_q.cnt == `BCH_RST_BYTE) begin
          s_d.st = bch_pkg::BCH_TMR_EXPIRED;
        end else begin
          s_d.cnt = s_q.cnt - `BCH_LAT_STEP;
        end
      end
      // Held until the frame ends
      bch_pkg::BCH_TMR_EXPIRED: begin
        if (!active) begin
          s_d.st = bch_pkg::BCH_TMR_IDLE;
        end
      end
      // Two-bit code 2'b11 is illegal
      default: begin
        s_d.st = bch_pkg::BCH_TMR_IDLE;
      end
    endcase
    s_d.expired = (s_d.st == bch_pkg::BCH_TMR_EXPIRED);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

endmodule

// file: bch_params.svh
// Offsets, fixed field values, reset values and timing counts of the bridge header block
`ifndef BCH_PARAMS_SVH
`define BCH_PARAMS_SVH

// Dword byte addresses in configuration space
`define BCH_OFF_CLASS 8'h08
`define BCH_OFF_MISC 8'h0c
`define BCH_OFF_BUS 8'h18
`define BCH_OFF_IO 8'h1c
`define BCH_OFF_IO_UP 8'h30

// Fixed identification fields
`define BCH_PROG_IF 8'h00
`define BCH_SUB_CLASS 8'h04
`define BCH_BASE_CLASS 8'h06
`define BCH_HDR_KIND 8'h01
`define BCH_IO_32BIT 4'h1

// Field positions inside the dwords
`define BCH_BYTE0_LSB 0
`define BCH_BYTE1_LSB 8
`define BCH_BYTE2_LSB 16
`define BCH_BYTE3_LSB 24
`define BCH_IO_NIB_LSB 4
`define BCH_IO_LIM_LSB 12

// Reset values and limits
`define BCH_RST_BYTE 8'h00
`define BCH_RST_NIB 4'h0
`define BCH_LS_MAX 8'h10
`define BCH_IO_LOW_BASE 12'h000
`define BCH_IO_LOW_LIMIT 12'hfff

// Timing: latency timers count one unit per PCI clock
`define BCH_CLK_NS 10
`define BCH_LAT_STEP 8'h01

`endif

// file: bch_pkg.sv
// Types shared by the bridge header block
package bch_pkg;

  // One configuration byte
  typedef logic [7:0] bch_byte_t;

  // Latency timer states
  typedef enum logic [1:0] {
    BCH_TMR_IDLE = 2'b00,
    BCH_TMR_RUN = 2'b01,
    BCH_TMR_EXPIRED = 2'b10
  } bch_tmr_e;

  // Whole state of one latency timer
  typedef struct packed {
    bch_tmr_e st;
    bch_byte_t cnt;
    logic expired;
  } bch_tmr_s;

  // Whole state of the header register block
  typedef struct packed {
    logic [31:0] rdata;
    bch_byte_t line_size;
    bch_byte_t prim_lat;
    bch_byte_t pbus;
    bch_byte_t sbus;
    bch_byte_t subbus;
    bch_byte_t slat;
    logic [3:0] io_base_hi;
    logic [3:0] io_limit_hi;
    logic [15:0] io_base_up;
    logic [15:0] io_limit_up;
    logic io_fwd;
    logic line_end;
    logic line_ok;
    logic cfg_local;
    logic cfg_behind;
  } bch_regs_s;

endpackage

// file: tb.sv
// Self-checking bench for the bridge header register block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] fst = 2'b00; // Frame starts, bit 1 secondary
  logic [1:0] fact = 2'b00; // Frame active / unclaimed
  wire [1:0] xp; // Expiry flags, one driver per bit
  logic [31:0] io_addr = 32'h0;
  logic [31:0] mem_addr = 32'h0;
  logic io_addr_valid = 1'b0;
  logic [7:0] cfg_bus = 8'h00;
  logic [7:0] cfg_addr, line_size;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [3:0] cfg_be;
  logic cfg_wr, cfg_rd, io_fwd, line_end, line_size_ok, cfg_local, cfg_behind;
  integer seed = 32'h464380c8;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] mdl [0:63] = '{default: 32'h0}; // Register model by dword
  logic [7:0] adr [6] = '{8'h08, 8'h0c, 8'h18, 8'h1c, 8'h30, 8'h04};
  logic [7:0] a, ls, cb;
  logic [31:0] d, k, lo, hi;
  int c;
  always #5 clk = ~clk;
  bch_host host (.clk, .cfg_rdata, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_wr, .cfg_rd);
  bch_cfg_regs #(.REV_LEVEL(REV)) dut (.clk, .rst, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_wr,
    .cfg_rd, .cfg_rdata, .pri_frame_start(fst[0]), .pri_frame_active(fact[0]),
    .pri_lat_expired(xp[0]), .sec_frame_start(fst[1]), .sec_unclaimed(fact[1]),
    .sec_lat_expired(xp[1]), .io_addr, .io_addr_valid, .io_fwd, .mem_addr, .line_end,
    .line_size_ok, .line_size, .cfg_bus, .cfg_local, .cfg_behind);
  // Writable bits per dword; everything else is fixed
  function automatic logic [31:0] wmask(input logic [7:0] x);
    case (x)
      8'h0c: return 32'h0000ffff;
      8'h18, 8'h30: return 32'hffffffff;
      8'h1c: return 32'h0000f0f0;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] fixv(input logic [7:0] x);
    case (x)
      8'h08: return {24'h060400, REV};
      8'h0c: return 32'h00010000;
      8'h1c: return 32'h00000101;
      default: return 32'h0;
    endcase
  endfunction
  // Write through the host and mirror enabled writable bytes
  task automatic mwr(input logic [7:0] x, input logic [31:0] v, input logic [3:0] b);
    logic [31:0] bm;
    bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wmask(x);
    mdl[x[7:2]] = (mdl[x[7:2]] & ~bm) | (v & bm);
    host.wr(x, v, b);
  endtask
  task automatic chk_rd(input logic [7:0] x);
    logic [31:0] got;
    host.rd(x, got);
    `CHK("rdata", (mdl[x[7:2]] & wmask(x)) | fixv(x), got);
  endtask
  // Load a timer, start a frame, time the expiry, then end the frame
  task automatic tmr(input int s, input logic [7:0] n);
    mwr(s ? 8'h18 : 8'h0c, {n, 8'h0, n, 8'h0}, s ? 4'b1000 : 4'b0010);
    @(posedge clk);
    fst[s] <= 1'b1;
    fact[s] <= 1'b1;
    @(posedge clk);
    fst <= 2'b00;
    c = 0;
    // Flags are read mid-cycle, where they have settled
    @(negedge clk);
    while (c < 300 && xp[s] !== 1'b1) begin
      @(negedge clk);
      c++;
    end
    `CHK("expiry", n + 1, c);
    if (c >= 300) results();
    @(posedge clk);
    fact <= 2'b00;
    @(negedge clk);
    `CHK("expiry hold", 1'b1, xp[s]);
    @(negedge clk);
    `CHK("expiry drop", 1'b0, xp[s]);
  endtask
  task automatic results;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (adr[i]) chk_rd(adr[i]);
    repeat (40) begin
      a = adr[$unsigned($random(seed)) % 6];
      d = $random(seed);
      c = $unsigned($random(seed)) % 6;
      d[7:0] = (c == 0) ? 8'h00 : 8'h01 << (c - 1);
      mwr(a, d, 4'($random(seed)));
      chk_rd(a);
    end
    mwr(8'h30, 32'h00020001, 4'hf);
    repeat (30) begin
      @(posedge clk);
      k = $random(seed);
      ls = mdl[3][7:0];
      cb = mdl[6][15:8] + {6'h0, k[19:18]} - 8'h01;
      lo = {mdl[12][15:0], mdl[7][7:4], 12'h000};
      hi = {mdl[12][31:16], mdl[7][15:12], 12'hfff};
      io_addr <= {14'h0, k[17:0]};
      io_addr_valid <= k[20];
      cfg_bus <= cb;
      mem_addr <= k;
      @(posedge clk);
      @(negedge clk);
      `CHK("io_fwd", k[20] && k[17:0] >= lo && k[17:0] <= hi, io_fwd);
      `CHK("line_size", ls, line_size);
      `CHK("line_ok", ls != 8'h00, line_size_ok);
      `CHK("line_end", ls == 8'h00 || (k[9:2] & (ls - 1)) == ls - 1, line_end);
      `CHK("local", cb == mdl[6][15:8], cfg_local);
      `CHK("behind", cb > mdl[6][15:8] && cb <= mdl[6][23:16], cfg_behind);
    end
    for (int i = 0; i < 6; i++) tmr(i % 2, 8'($unsigned($random(seed)) % 8));
    // Second reset in mid-run must restore every writable field
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (mdl[i]) mdl[i] = 32'h0;
    foreach (adr[i]) chk_rd(adr[i]);
    results();
  end
endmodule
